// ==== css_core_seq.sv ====
`timescale 1ns/1ps
`include "css_map.svh"
module css_core_seq (
  // Clock and reset
  input  wire logic                         i_clk,
  input  wire logic                         i_rst,
  // Instruction stream
  input  wire css_pkg::css_op_t             i_op,
  input  wire logic                         i_op_valid,
  output logic                              o_op_ready,
  output logic      [`CSS_PC_BITS-1:0]      o_pc,
  // ALU
  output css_pkg::css_alu_in_t              o_alu,
  input  wire css_pkg::css_alu_out_t        i_alu,
  // Data space
  output css_pkg::css_dmem_req_t            o_dmem,
  input  wire logic [7:0]                   i_dmem_rdata,
  // Interrupt sources
  input  wire logic [`CSS_NUM_IRQ-1:0]      i_irq_event,
  input  wire logic [`CSS_NUM_IRQ-1:0]      i_irq_level,
  input  wire logic [`CSS_NUM_IRQ-1:0]      i_irq_enable,
  input  wire logic [`CSS_NUM_IRQ-1:0]      i_irq_flag_wr1,
  output logic      [`CSS_NUM_IRQ-1:0]      o_irq_flag,
  output logic      [`CSS_NUM_IRQ-1:0]      o_irq_ack,
  // Boot straps and lock bits
  input  wire logic                         i_vector_table_select,
  input  wire logic                         i_reset_vector_relocate_fuse,
  input  wire logic                         i_app_lock_bit_b,
  input  wire logic                         i_boot_lock_bit_b,
  // Core state
  output logic      [7:0]                   o_cpu_status_flags,
  output logic      [15:0]                  o_sp
);

  function automatic logic [`CSS_PC_BITS-1:0] css_vector(input logic sel, input logic [3:0] num);
    css_vector = (sel ? `CSS_BOOT_START : 13'h0000) + 13'({num, 1'b0});
  endfunction

  function automatic logic css_io_hit(input logic [15:0] addr, input logic [15:0] io);
    css_io_hit = (addr == (`CSS_IO_BASE + io));
  endfunction

  css_pkg::css_state_t         state;
  logic [1:0]                  cnt;
  logic [`CSS_PC_BITS-1:0]     pc;
  logic [`CSS_SP_BITS-1:0]     sp;
  logic [7:0]                  cpu_status_flags;
  logic                        inhibit;
  logic [`CSS_NUM_IRQ-1:0]     flag;
  logic [`CSS_PC_BITS-1:0]     tgt;
  logic [7:0]                  ret_hi;
  logic                        is_return_from_irq;
  logic [15:0]                 mem_addr;
  logic [7:0]                  mem_data;
  logic [4:0]                  ld_rd;
  logic                        ld_ext;
  logic [7:0]                  ld_int;

  logic [15:0]                 sp16;
  logic [7:0]                  ra;
  logic [7:0]                  rb;
  logic [15:0]                 rpair;
  logic [15:0]                 ptr_val;
  logic [15:0]                 eff_addr;
  logic [15:0]                 ptr_new;
  logic                        ptr_upd;
  logic                        eff_ext;
  logic [`CSS_NUM_IRQ-1:0]     req;
  logic [`CSS_NUM_IRQ-1:0]     win;
  logic [3:0]                  win_num;
  logic                        in_boot;
  logic                        blocked;
  logic                        take;
  logic                        exec;
  logic [`CSS_PC_BITS-1:0]     ret_pc;
  logic                        we8;
  logic [4:0]                  wa8;
  logic [7:0]                  wd8;
  logic                        we16;
  logic [3:0]                  wpair;
  logic [15:0]                 wd16;

  // Upper pointer bits are not stored at all
  assign sp16 = {{(16 - `CSS_SP_BITS){1'b0}}, sp};

  // Pointer addressing modes
  always_comb begin
    case (i_op.amode)
      css_pkg::AM_DIRECT:  eff_addr = i_op.imm;
      css_pkg::AM_DISP:    eff_addr = ptr_val + {10'h000, i_op.disp};
      css_pkg::AM_PREDEC:  eff_addr = ptr_val - 16'h0001;
      default:             eff_addr = ptr_val;
    endcase
  end
  assign ptr_new = (i_op.amode == css_pkg::AM_PREDEC) ? eff_addr : ptr_val + 16'h0001;
  assign ptr_upd = (i_op.amode == css_pkg::AM_POSTINC) || (i_op.amode == css_pkg::AM_PREDEC);
  assign eff_ext = (eff_addr >= `CSS_REG_SPACE_END) && !css_io_hit(eff_addr, `CSS_SP_LO_IO)
                   && !css_io_hit(eff_addr, `CSS_SP_HI_IO) && !css_io_hit(eff_addr, `CSS_STATUS_IO);

  // Interrupt arbitration, lowest index first
  assign req = (flag | i_irq_level) & i_irq_enable;
  always_comb begin
    win     = '0;
    win_num = 4'h0;
    for (int i = `CSS_NUM_IRQ - 1; i >= 0; i--) begin
      if (req[i]) begin
        win     = '0;
        win[i]  = 1'b1;
        win_num = 4'(i + 1);
      end
    end
  end

  assign in_boot = (pc >= `CSS_BOOT_START);
  assign blocked = (i_app_lock_bit_b && !in_boot && i_vector_table_select) ||
                   (i_boot_lock_bit_b && in_boot && !i_vector_table_select);

  // A clear-enable presented this cycle beats any request
  assign take = (state == css_pkg::S_RUN) && (|req) && cpu_status_flags[`CSS_GIE_BIT] && !inhibit && !blocked
                && !(i_op_valid && i_op.kind == css_pkg::OP_CLI);
  assign o_op_ready = (state == css_pkg::S_RUN) && !take;
  assign exec       = i_op_valid && o_op_ready;
  assign o_irq_ack  = take ? win : '0;
  assign ret_pc     = take ? pc : pc + {11'h000, i_op.two_word, !i_op.two_word};

  // Sequencer state
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= css_pkg::S_BOOT;
      cnt   <= 2'h0;
    end else begin
      cnt <= cnt + 2'h1;
      case (state)
        css_pkg::S_BOOT: begin
          state <= css_pkg::S_RUN;
        end
        css_pkg::S_RUN: begin
          cnt <= 2'h0;
          if (take) begin
            state <= css_pkg::S_PUSH;
          end else if (exec) begin
            case (i_op.kind)
              css_pkg::OP_CALL:  state <= css_pkg::S_PUSH;
              css_pkg::OP_RET,
              css_pkg::OP_RETURN_FROM_IRQ:  state <= css_pkg::S_RET;
              css_pkg::OP_POP,
              css_pkg::OP_LD:    state <= css_pkg::S_LOAD;
              css_pkg::OP_ST:    state <= css_pkg::S_STORE;
              css_pkg::OP_MULTI: begin
                state <= (i_op.extra == 2'h0) ? css_pkg::S_RUN : css_pkg::S_WAIT;
                cnt   <= i_op.extra - 2'h1;
              end
              default:           state <= css_pkg::S_RUN;
            endcase
          end
        end
        css_pkg::S_PUSH,
        css_pkg::S_RET: begin
          if (cnt == `CSS_CNT_LAST) begin
            state <= css_pkg::S_RUN;
          end
        end
        css_pkg::S_LOAD: begin
          if (cnt == 2'h1) begin
            state <= css_pkg::S_RUN;
          end
        end
        css_pkg::S_WAIT: begin
          cnt <= cnt - 2'h1;
          if (cnt == 2'h0) begin
            state <= css_pkg::S_RUN;
          end
        end
        default: begin
          state <= css_pkg::S_RUN;
        end
      endcase
    end
  end

  // Program counter and return target
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pc      <= 13'h0000;
      tgt     <= 13'h0000;
      ret_hi  <= 8'h00;
      is_return_from_irq <= 1'b0;
    end else begin
      if (state == css_pkg::S_BOOT) begin
        pc <= css_vector(i_reset_vector_relocate_fuse, 4'h0);
      end else if (take) begin
        tgt    <= css_vector(i_vector_table_select, win_num);
        ret_hi <= 8'(pc[`CSS_PC_BITS-1:8]);
      end else if (exec) begin
        is_return_from_irq <= (i_op.kind == css_pkg::OP_RETURN_FROM_IRQ);
        case (i_op.kind)
          css_pkg::OP_JMP: pc <= i_op.imm[`CSS_PC_BITS-1:0];
          css_pkg::OP_CALL: begin
            pc     <= ret_pc;
            tgt    <= i_op.imm[`CSS_PC_BITS-1:0];
            ret_hi <= 8'(ret_pc[`CSS_PC_BITS-1:8]);
          end
          default: pc <= ret_pc;
        endcase
      end else if (state == css_pkg::S_PUSH && cnt == `CSS_CNT_LAST) begin
        pc <= tgt;
      end else if (state == css_pkg::S_RET && cnt == 2'h1) begin
        ret_hi <= i_dmem_rdata;
      end else if (state == css_pkg::S_RET && cnt == `CSS_CNT_LAST) begin
        pc <= {ret_hi[`CSS_PC_BITS-9:0], i_dmem_rdata};
      end
    end
  end

  // Stack pointer
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sp <= 11'(`CSS_TOP_OF_DATA);
    end else begin
      if (take || (state == css_pkg::S_PUSH && cnt == 2'h0)) begin
        sp <= sp - 1'b1;
      end else if (state == css_pkg::S_RET && cnt == 2'h0) begin
        sp <= sp + 1'b1;
      end else if (exec && (i_op.kind == css_pkg::OP_PUSH || i_op.kind == css_pkg::OP_CALL)) begin
        sp <= sp - 1'b1;
      end else if (exec && (i_op.kind == css_pkg::OP_POP || i_op.kind == css_pkg::OP_RET ||
                            i_op.kind == css_pkg::OP_RETURN_FROM_IRQ)) begin
        sp <= sp + 1'b1;
      end else if (state == css_pkg::S_STORE && css_io_hit(mem_addr, `CSS_SP_LO_IO)) begin
        sp[7:0] <= mem_data;
      end else if (state == css_pkg::S_STORE && css_io_hit(mem_addr, `CSS_SP_HI_IO)) begin
        sp[`CSS_SP_BITS-1:8] <= mem_data[`CSS_SP_BITS-9:0];
      end
    end
  end

  // Status flags and the enable guard; the flags are not stacked on entry
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cpu_status_flags    <= `CSS_STATUS_RESET;
      inhibit <= 1'b0;
    end else begin
      if (take) begin
        cpu_status_flags[`CSS_GIE_BIT] <= 1'b0;
      end else if (exec) begin
        inhibit <= (i_op.kind == css_pkg::OP_SEI);
        case (i_op.kind)
          css_pkg::OP_SEI: cpu_status_flags[`CSS_GIE_BIT] <= 1'b1;
          css_pkg::OP_CLI: cpu_status_flags[`CSS_GIE_BIT] <= 1'b0;
          css_pkg::OP_ALU_1R,
          css_pkg::OP_ALU_2R,
          css_pkg::OP_ALU_2R16,
          css_pkg::OP_ALU_1R16: begin
            for (int i = 0; i < 7; i++) begin
              if (i_alu.flags_we[i]) begin
                cpu_status_flags[i] <= i_alu.flags[i];
              end
            end
          end
          default: begin
          end
        endcase
      end else if (state == css_pkg::S_STORE && css_io_hit(mem_addr, `CSS_STATUS_IO)) begin
        cpu_status_flags <= mem_data;
      end else if (state == css_pkg::S_RET && cnt == `CSS_CNT_LAST && is_return_from_irq) begin
        cpu_status_flags[`CSS_GIE_BIT] <= 1'b1;
        inhibit            <= 1'b1;
      end
    end
  end

  // Pending flags; a new event outranks any clear in the same cycle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      flag <= '0;
    end else begin
      flag <= (flag & ~i_irq_flag_wr1 & ~o_irq_ack) | i_irq_event;
    end
  end

  // Data-space requests, one cycle after the decision
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_dmem <= '0;
    end else begin
      o_dmem.we <= 1'b0;
      o_dmem.re <= 1'b0;
      if (take) begin
        o_dmem <= '{addr: sp16, wdata: pc[7:0], we: 1'b1, re: 1'b0};
      end else if (state == css_pkg::S_PUSH && cnt == 2'h0) begin
        o_dmem <= '{addr: sp16, wdata: ret_hi, we: 1'b1, re: 1'b0};
      end else if (state == css_pkg::S_RET && cnt == 2'h0) begin
        o_dmem <= '{addr: sp16 + 16'h0001, wdata: 8'h00, we: 1'b0, re: 1'b1};
      end else if (exec) begin
        case (i_op.kind)
          css_pkg::OP_PUSH: o_dmem <= '{addr: sp16, wdata: rb, we: 1'b1, re: 1'b0};
          css_pkg::OP_CALL: o_dmem <= '{addr: sp16, wdata: ret_pc[7:0], we: 1'b1, re: 1'b0};
          css_pkg::OP_POP,
          css_pkg::OP_RET,
          css_pkg::OP_RETURN_FROM_IRQ: o_dmem <= '{addr: sp16 + 16'h0001, wdata: 8'h00, we: 1'b0, re: 1'b1};
          css_pkg::OP_LD:   o_dmem <= '{addr: eff_addr, wdata: 8'h00, we: 1'b0, re: eff_ext};
          css_pkg::OP_ST:   o_dmem <= '{addr: eff_addr, wdata: rb, we: eff_ext, re: 1'b0};
          default: begin
          end
        endcase
      end
    end
  end

  // Load and store bookkeeping; internal sources are sampled at issue
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mem_addr <= 16'h0000;
      mem_data <= 8'h00;
      ld_rd    <= 5'h00;
      ld_ext   <= 1'b0;
      ld_int   <= 8'h00;
    end else if (exec) begin
      mem_addr <= eff_addr;
      mem_data <= rb;
      ld_rd    <= (i_op.kind == css_pkg::OP_POP) ? i_op.rr : i_op.rd;
      ld_ext   <= (i_op.kind == css_pkg::OP_POP) || eff_ext;
      if (eff_addr < `CSS_REG_SPACE_END) begin
        ld_int <= ra;
      end else if (css_io_hit(eff_addr, `CSS_SP_LO_IO)) begin
        ld_int <= sp16[7:0];
      end else if (css_io_hit(eff_addr, `CSS_SP_HI_IO)) begin
        ld_int <= sp16[15:8];
      end else begin
        ld_int <= cpu_status_flags;
      end
    end
  end

  // Register write-back selection
  always_comb begin
    we8   = 1'b0;
    wa8   = i_op.rd;
    wd8   = i_alu.res[7:0];
    we16  = 1'b0;
    wpair = i_op.rd[4:1];
    wd16  = i_alu.res;
    if (exec) begin
      case (i_op.kind)
        css_pkg::OP_ALU_1R,
        css_pkg::OP_ALU_2R:   we8 = 1'b1;
        css_pkg::OP_ALU_2R16: begin
          we16  = 1'b1;
          wpair = 4'h0;
        end
        css_pkg::OP_ALU_1R16: we16 = 1'b1;
        css_pkg::OP_LD,
        css_pkg::OP_ST: begin
          we16  = ptr_upd;
          wpair = {2'b11, i_op.ptr};
          wd16  = ptr_new;
        end
        default: begin
        end
      endcase
    end else if (state == css_pkg::S_LOAD && cnt == 2'h1) begin
      we8 = 1'b1;
      wa8 = ld_rd;
      wd8 = ld_ext ? i_dmem_rdata : ld_int;
    end else if (state == css_pkg::S_STORE && mem_addr < `CSS_REG_SPACE_END) begin
      we8 = 1'b1;
      wa8 = mem_addr[4:0];
      wd8 = mem_data;
    end
  end

  css_regfile u_regfile (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_addr_a ((i_op.kind == css_pkg::OP_LD) ? eff_addr[4:0] : i_op.rd),
    .i_addr_b (i_op.rr),
    .i_pair   (i_op.rd[4:1]),
    .i_ptr    (i_op.ptr),
    .o_a      (ra),
    .o_b      (rb),
    .o_pair   (rpair),
    .o_ptr    (ptr_val),
    .i_we8    (we8),
    .i_wa8    (wa8),
    .i_wd8    (wd8),
    .i_we16   (we16),
    .i_wpair  (wpair),
    .i_wd16   (wd16)
  );

  // Operands leave combinationally so the ALU result returns the same cycle
  assign o_alu              = '{opa: ra, opb: rb, opw: rpair};
  assign o_pc               = pc;
  assign o_sp               = sp16;
  assign o_cpu_status_flags = cpu_status_flags;
  assign o_irq_flag         = flag;

endmodule

// ==== css_core_seq_properties.sv ====
`timescale 1ns/1ps
module css_core_seq_properties (
  // Clock and reset
  input wire logic             i_clk,
  input wire logic             i_rst,
  // Instruction stream
  input wire css_pkg::css_op_t i_op,
  input wire logic             i_op_valid,
  input wire logic             o_op_ready,
  input wire logic [12:0]      o_pc,
  // Interrupts
  input wire logic [7:0]       i_irq_event,
  input wire logic [7:0]       i_irq_level,
  input wire logic [7:0]       i_irq_enable,
  input wire logic [7:0]       o_irq_flag,
  input wire logic [7:0]       o_irq_ack,
  input wire logic             i_vector_table_select,
  // Core state
  input wire logic [7:0]       o_cpu_status_flags,
  input wire logic [15:0]      o_sp
);
  logic [12:0] vec;
  logic        take;
  logic [7:0]  pend;

  // Expected vector of the source acknowledged now
  always_comb begin
    vec = 13'h0000;
    for (int i = 7; i >= 0; i--) begin
      if (o_irq_ack[i]) vec = 13'(2 * (i + 1));
    end
    if (i_vector_table_select) vec = vec + 13'h1c00;
  end
  assign take = i_op_valid && o_op_ready;
  assign pend = (o_irq_flag | i_irq_level) & i_irq_enable;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  chk_ack_onehot: assert property ($onehot0(o_irq_ack))
    else $error("more than one ack");
  chk_ack_enables: assert property (|o_irq_ack |-> o_cpu_status_flags[7] && |(o_irq_ack & pend))
    else $error("ack without both enables");
  chk_ack_priority: assert property (|o_irq_ack |-> ((o_irq_ack - 8'h01) & pend) == 8'h00)
    else $error("lower source skipped");
  chk_gie_cleared: assert property (|o_irq_ack |=> !o_cpu_status_flags[7])
    else $error("global enable kept on entry");
  chk_flag_cleared: assert property ((|o_irq_ack && (o_irq_ack & i_irq_event) == 8'h00)
    |=> (o_irq_flag & $past(o_irq_ack)) == 8'h00)
    else $error("flag kept after vectoring");
  chk_entry_busy: assert property (|o_irq_ack |-> !o_op_ready [*4])
    else $error("entry shorter than four cycles");
  chk_entry_vector: assert property (|o_irq_ack |-> ##4 o_pc == $past(vec, 4))
    else $error("wrong vector");
  chk_entry_stack: assert property (|o_irq_ack |-> ##4 o_sp == $past(o_sp, 4) - 16'h0002)
    else $error("entry did not push two bytes");
  chk_sei_hold: assert property (take && i_op.kind == css_pkg::OP_SEI |=> o_irq_ack == 8'h00)
    else $error("ack right after set-enable");
  chk_cli_block: assert property (i_op_valid && i_op.kind == css_pkg::OP_CLI |-> o_irq_ack == 8'h00)
    else $error("ack beside clear-enable");
  chk_return_from_irq_gie: assert property (take && i_op.kind == css_pkg::OP_RETURN_FROM_IRQ
    |-> ##4 o_cpu_status_flags[7])
    else $error("return left enable off");
  chk_sp_reset: assert property ($past(i_rst) |-> o_sp == 16'h04ff)
    else $error("bad pointer reset value");
  chk_sp_upper: assert property (o_sp[15:11] == 5'h00)
    else $error("unused pointer bits set");

  cover property (|o_irq_ack);
  cover property (take && i_op.kind == css_pkg::OP_RETURN_FROM_IRQ);
  cover property (i_op_valid && i_op.kind == css_pkg::OP_CLI && |pend);
endmodule

bind css_core_seq css_core_seq_properties props (.i_clk, .i_rst, .i_op, .i_op_valid,
  .o_op_ready, .o_pc, .i_irq_event, .i_irq_level, .i_irq_enable, .o_irq_flag, .o_irq_ack,
  .i_vector_table_select, .o_cpu_status_flags, .o_sp);

// ==== css_core_seq_tb.sv ====
`timescale 1ns/1ps
module css_core_seq_tb;
  logic                   i_clk = 1'b0;
  logic                   i_rst = 1'b1;
  css_pkg::css_op_t       op = '0;
  css_pkg::css_alu_in_t   alu_i;
  css_pkg::css_alu_out_t  alu_o;
  css_pkg::css_dmem_req_t dm;
  logic [7:0]             ev = 8'h00, lvl = 8'h00, en = 8'h00, en_nx = 8'h00, wr1 = 8'h00;
  logic [7:0]             rdata, flag, ack, sr, ackv;
  logic                   vld = 1'b0, sel = 1'b0, lk = 1'b0, rdy;
  logic [12:0]            pc, rpc;
  logic [15:0]            sp;
  int                     miscompares, compares, acks, exp_sp, lo, hi;
  css_pkg::css_op_kind_t  kinds [4] = '{css_pkg::OP_PUSH, css_pkg::OP_CALL,
                                        css_pkg::OP_RET, css_pkg::OP_POP};
  int                     deltas [4] = '{-1, -2, 2, 1};

  always #2.5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    if (ack !== 8'h00) begin
      acks++;
      ackv = ack;
    end
  end

  css_core_seq dut (.i_clk, .i_rst, .i_op(op), .i_op_valid(vld), .o_op_ready(rdy), .o_pc(pc),
    .o_alu(alu_i), .i_alu(alu_o), .o_dmem(dm), .i_dmem_rdata(rdata), .i_irq_event(ev),
    .i_irq_level(lvl), .i_irq_enable(en), .i_irq_flag_wr1(wr1), .o_irq_flag(flag),
    .o_irq_ack(ack), .i_vector_table_select(sel), .i_reset_vector_relocate_fuse(1'b0),
    .i_app_lock_bit_b(lk), .i_boot_lock_bit_b(1'b0), .o_cpu_status_flags(sr), .o_sp(sp));
  css_far_model far (.i_clk, .i_dmem(dm), .o_rdata(rdata), .i_alu(alu_i), .o_alu(alu_o));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    #1;
    while (rdy !== 1'b1 && n < 40) begin
      @(negedge i_clk);
      #1;
      n++;
    end
    chk(16'(rdy), 16'h0001);
  endtask

  task automatic run(input css_pkg::css_op_kind_t k);
    @(negedge i_clk);
    op.kind = k;
    vld = 1'b1;
    en = en_nx;
    wait_rdy();
    @(negedge i_clk);
    vld = 1'b0;
  endtask

  task automatic idle();
    wait_rdy();
    repeat (2) @(negedge i_clk);
  endtask

  task automatic pulse_ev(input logic [7:0] v);
    @(negedge i_clk);
    ev = v;
    @(negedge i_clk);
    ev = 8'h00;
  endtask

  // Enable op, then one op that must run before the entry
  task automatic take(input css_pkg::css_op_kind_t k, input int idx, input int d);
    logic [15:0] sp0;
    sp0 = sp;
    acks = 0;
    run(k);
    run(css_pkg::OP_NOP);
    rpc = pc;
    chk(16'(acks), 16'h0000);
    idle();
    chk(16'(acks), 16'h0001);
    chk(16'(ackv), 16'h0001 << idx);
    chk(16'(pc), (sel ? 16'h1c00 : 16'h0000) + 16'(2 * (idx + 1)));
    chk(sp, sp0 + 16'(d));
    chk(16'(sr[7]), 16'h0000);
    chk(16'(flag[idx]), 16'h0000);
  endtask

  task automatic stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #20000;
    miscompares++;
    stop_test();
  end

  initial begin
    void'($urandom(36));
    repeat (2) @(negedge i_clk);
    i_rst = 1'b0;
    chk(sp, 16'h04ff);
    repeat (2) @(negedge i_clk);
    chk(16'(pc), 16'h0000);
    exp_sp = 'h4ff;
    for (int i = 0; i < 4; i++) begin
      op.two_word = (i == 1);
      if (i == 1) rpc = pc;
      run(kinds[i]);
      idle();
      exp_sp += deltas[i];
      chk(sp, 16'(exp_sp));
      if (i == 2) chk(16'(pc), 16'(rpc) + 16'h0002);
    end
    op.extra = 2'h2;
    run(css_pkg::OP_MULTI);
    repeat (2) begin
      #1;
      chk(16'(rdy), 16'h0000);
      @(negedge i_clk);
    end
    #1;
    chk(16'(rdy), 16'h0001);
    $display("stack test done");
    sel = 1'($urandom % 2);
    lo = $urandom % 4;
    hi = 4 + $urandom % 4;
    en_nx = (8'h01 << lo) | (8'h01 << hi);
    en = en_nx;
    pulse_ev(en_nx);
    repeat (3) @(negedge i_clk);
    chk(16'(flag), 16'(en_nx));
    take(css_pkg::OP_SEI, lo, -2);
    chk(16'(flag), 16'h0001 << hi);
    take(css_pkg::OP_RETURN_FROM_IRQ, hi, 0);
    run(css_pkg::OP_RETURN_FROM_IRQ);
    idle();
    chk(16'(sr[7]), 16'h0001);
    chk(16'(pc), 16'(rpc));
    chk(sp, 16'(exp_sp));
    $display("interrupt test done");
    // Request pending before clear-enable, enabled in its cycle
    en_nx = 8'h00;
    en = 8'h00;
    pulse_ev(8'h01 << lo);
    // Clears the guard so only the clear-enable can hold the request off
    run(css_pkg::OP_NOP);
    acks = 0;
    en_nx = 8'hff;
    run(css_pkg::OP_CLI);
    repeat (4) @(negedge i_clk);
    chk(16'(acks), 16'h0000);
    chk(16'(flag), 16'h0001 << lo);
    wr1 = flag;
    @(negedge i_clk);
    wr1 = 8'h00;
    #1;
    chk(16'(flag), 16'h0000);
    lvl = 8'h08;
    @(negedge i_clk);
    lvl = 8'h00;
    acks = 0;
    run(css_pkg::OP_SEI);
    run(css_pkg::OP_NOP);
    repeat (3) @(negedge i_clk);
    chk(16'(acks), 16'h0000);
    $display("clear and level test done");
    sel = 1'b1;
    lk = 1'b1;
    acks = 0;
    pulse_ev(8'h01);
    repeat (3) @(negedge i_clk);
    chk(16'(acks), 16'h0000);
    lk = 1'b0;
    idle();
    chk(16'(acks), 16'h0001);
    chk(16'(pc), 16'h1c02);
    op.ptr = css_pkg::PTR_X;
    op.amode = css_pkg::AM_POSTINC;
    op.rr = 5'd26;
    repeat (2) run(css_pkg::OP_ST);
    idle();
    op.rd = 5'd1;
    #1;
    chk(alu_i.opw, 16'h0100);
    @(negedge i_clk);
    op.rd = 5'd26;
    #1;
    chk(alu_i.opw, 16'h0002);
    $display("lock and pointer test done");
    stop_test();
  end
endmodule

// ==== css_far_model.sv ====
`timescale 1ns/1ps
module css_far_model (
  // Clock
  input  wire logic                   i_clk,
  // Data space
  input  wire css_pkg::css_dmem_req_t i_dmem,
  output logic [7:0]                  o_rdata,
  // ALU
  input  wire css_pkg::css_alu_in_t   i_alu,
  output css_pkg::css_alu_out_t       o_alu
);
  logic [7:0] mem [0:2047];

  // Idle bus inverts the last byte each cycle, so a stale byte shows again on every second idle cycle
  always @(posedge i_clk) begin
    if (i_dmem.re) o_rdata <= mem[i_dmem.addr[10:0]];
    else o_rdata <= ~o_rdata;
  end
  always @(posedge i_clk) begin
    if (i_dmem.we) mem[i_dmem.addr[10:0]] <= i_dmem.wdata;
  end
  assign o_alu = '{res: {i_alu.opb, i_alu.opa + i_alu.opb}, flags: 7'h00, flags_we: 7'h00};
endmodule

// ==== css_map.svh ====
`ifndef CSS_MAP_SVH
`define CSS_MAP_SVH

// Register file and data-space layout
`define CSS_NUM_REGS      32
`define CSS_REG_SPACE_END 16'h0020
`define CSS_IO_BASE       16'h0020
`define CSS_SP_LO_IO      16'h003d
`define CSS_SP_HI_IO      16'h003e
`define CSS_STATUS_IO     16'h003f

// Stack pointer
`define CSS_SP_BITS       11
`define CSS_TOP_OF_DATA   16'h04ff

// Program counter and vectors
`define CSS_PC_BITS       13
`define CSS_BOOT_START    13'h1c00
`define CSS_NUM_IRQ       8

// Status register fields
`define CSS_GIE_BIT       7
`define CSS_STATUS_RESET  8'h00

// Timing counts in clock cycles
`define CSS_ENTRY_CYCLES  4
`define CSS_RETURN_CYCLES 4
`define CSS_CNT_LAST      2'h2

`endif

// ==== css_pkg.sv ====
package css_pkg;

  typedef enum logic [3:0] {
    OP_NOP      = 4'h0,
    OP_ALU_1R   = 4'h1,
    OP_ALU_2R   = 4'h2,
    OP_ALU_2R16 = 4'h3,
    OP_ALU_1R16 = 4'h4,
    OP_PUSH     = 4'h5,
    OP_POP      = 4'h6,
    OP_CALL     = 4'h7,
    OP_RET      = 4'h8,
    OP_RETURN_FROM_IRQ     = 4'h9,
    OP_SEI      = 4'ha,
    OP_CLI      = 4'hb,
    OP_LD       = 4'hc,
    OP_ST       = 4'hd,
    OP_JMP      = 4'he,
    OP_MULTI    = 4'hf
  } css_op_kind_t;

  typedef enum logic [2:0] {
    AM_DIRECT  = 3'h0,
    AM_PLAIN   = 3'h1,
    AM_DISP    = 3'h2,
    AM_POSTINC = 3'h3,
    AM_PREDEC  = 3'h4
  } css_amode_t;

  typedef enum logic [1:0] {
    PTR_X = 2'h1,
    PTR_Y = 2'h2,
    PTR_Z = 2'h3
  } css_ptr_t;

  typedef enum logic [2:0] {
    S_BOOT  = 3'h0,
    S_RUN   = 3'h1,
    S_PUSH  = 3'h2,
    S_RET   = 3'h3,
    S_LOAD  = 3'h4,
    S_STORE = 3'h5,
    S_WAIT  = 3'h6
  } css_state_t;

  typedef struct packed {
    css_op_kind_t kind;
    logic [4:0]   rd;
    logic [4:0]   rr;
    css_ptr_t     ptr;
    css_amode_t   amode;
    logic [5:0]   disp;
    logic [15:0]  imm;
    logic         two_word;
    logic [1:0]   extra;
  } css_op_t;

  typedef struct packed {
    logic [7:0]  opa;
    logic [7:0]  opb;
    logic [15:0] opw;
  } css_alu_in_t;

  typedef struct packed {
    logic [15:0] res;
    logic [6:0]  flags;
    logic [6:0]  flags_we;
  } css_alu_out_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic        re;
  } css_dmem_req_t;

endpackage

// ==== css_regfile.sv ====
`timescale 1ns/1ps
`include "css_map.svh"
module css_regfile (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Read ports
  input  wire logic [4:0]  i_addr_a,
  input  wire logic [4:0]  i_addr_b,
  input  wire logic [3:0]  i_pair,
  input  wire logic [1:0]  i_ptr,
  output logic      [7:0]  o_a,
  output logic      [7:0]  o_b,
  output logic      [15:0] o_pair,
  output logic      [15:0] o_ptr,
  // Write ports
  input  wire logic        i_we8,
  input  wire logic [4:0]  i_wa8,
  input  wire logic [7:0]  i_wd8,
  input  wire logic        i_we16,
  input  wire logic [3:0]  i_wpair,
  input  wire logic [15:0] i_wd16
);

  logic [7:0] mem [0:`CSS_NUM_REGS-1];

  // Reads stay combinational so operands, ALU and write-back fit one cycle
  assign o_a    = mem[i_addr_a];
  assign o_b    = mem[i_addr_b];
  assign o_pair = {mem[{i_pair, 1'b1}], mem[{i_pair, 1'b0}]};
  assign o_ptr  = {mem[{2'b11, i_ptr, 1'b1}], mem[{2'b11, i_ptr, 1'b0}]};

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < `CSS_NUM_REGS; i++) begin
        mem[i] <= 8'h00;
      end
    end else begin
      if (i_we16) begin
        mem[{i_wpair, 1'b0}] <= i_wd16[7:0];
        mem[{i_wpair, 1'b1}] <= i_wd16[15:8];
      end
      if (i_we8) begin
        mem[i_wa8] <= i_wd8;
      end
    end
  end

endmodule
